// File: hdl/teq_consts.vh
// constants for the termination error qualifier
`ifndef TEQ_CONSTS_VH
`define TEQ_CONSTS_VH
`define TEQ_PRI_TLB      3'h0
`define TEQ_PRI_STORAGE  3'h1
`define TEQ_PRI_ALIGN    3'h2
`define TEQ_PRI_TAGPAR   3'h3
`define TEQ_PRI_DATAPAR  3'h4
`define TEQ_PRI_EXT      3'h5
`define TEQ_PRI_NONE     3'h6
`define TEQ_KIND_NONE    3'h0
`define TEQ_KIND_TLB     3'h1
`define TEQ_KIND_STORAGE 3'h2
`define TEQ_KIND_ALIGN   3'h3
`define TEQ_KIND_BYTEORD 3'h4
`define TEQ_KIND_TAGPAR  3'h5
`define TEQ_KIND_DATAPAR 3'h6
`define TEQ_KIND_EXT     3'h7
`define TEQ_SYN_W        4
`define TEQ_SYN_ITAG     0
`define TEQ_SYN_IDATA    1
`define TEQ_SYN_DTAG     2
`define TEQ_SYN_DDATA    3
`define TEQ_SYN_RST      4'h0
`define TEQ_ADDR_RST     32'h00000000
`endif

// File: hdl/teq_decode.v
// one-port termination qualifier decoder, combinational
`default_nettype none
`include "teq_consts.vh"
module teq_decode (
  input  wire       term_ack_n,
  input  wire       term_err_n,
  input  wire       tlb_miss_n,
  input  wire       align_err_n,
  input  wire       byte_ord_n,
  input  wire       tag_par_n,
  input  wire       data_par_n,
  input  wire       ext_err_n,
  output reg  [2:0] kind,
  output reg  [2:0] prio,
  output reg        invalid,
  output wire       ok_done,
  output wire       any_done
);
  wire [5:0] q;
  assign q = ~{tlb_miss_n, align_err_n, byte_ord_n,
               tag_par_n, data_par_n, ext_err_n};
  // error ack wins over plain ack
  assign ok_done  = ~term_ack_n & term_err_n;
  assign any_done = ~term_ack_n | ~term_err_n;
  always @* begin
    kind    = `TEQ_KIND_NONE;
    prio    = `TEQ_PRI_NONE;
    invalid = 1'b0;
    if (term_err_n) begin
      kind = `TEQ_KIND_NONE;
      prio = `TEQ_PRI_NONE;
    end else begin
      // qualifiers only looked at under error ack
      case (q)
        6'h20: begin
          kind = `TEQ_KIND_TLB;
          prio = `TEQ_PRI_TLB;
        end
        6'h00: begin
          kind = `TEQ_KIND_STORAGE;
          prio = `TEQ_PRI_STORAGE;
        end
        6'h10: begin
          kind = `TEQ_KIND_ALIGN;
          prio = `TEQ_PRI_ALIGN;
        end
        6'h08: begin
          kind = `TEQ_KIND_BYTEORD;
          prio = `TEQ_PRI_ALIGN;
        end
        6'h04: begin
          kind = `TEQ_KIND_TAGPAR;
          prio = `TEQ_PRI_TAGPAR;
        end
        6'h02: begin
          kind = `TEQ_KIND_DATAPAR;
          prio = `TEQ_PRI_DATAPAR;
        end
        6'h01: begin
          kind = `TEQ_KIND_EXT;
          prio = `TEQ_PRI_EXT;
        end
        default: begin
          // any flag combination is flagged invalid; tlb miss kind if tlb is set, else storage
          if (q[5]) begin
            kind = `TEQ_KIND_TLB;
            prio = `TEQ_PRI_TLB;
          end else begin
            kind = `TEQ_KIND_STORAGE;
            prio = `TEQ_PRI_STORAGE;
          end
          invalid = 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hdl/teq_qualifier.v
// termination status and error qualification for both memory ports
`default_nettype none
`include "teq_consts.vh"
module teq_qualifier (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        d_term_ack_n,
  input  wire        d_term_err_n,
  input  wire        d_tlb_miss_n,
  input  wire        d_align_err_n,
  input  wire        d_byte_ord_n,
  input  wire        d_tag_par_n,
  input  wire        d_data_par_n,
  input  wire        d_ext_err_n,
  input  wire        term_guarded,
  input  wire        term_uncached,
  input  wire [31:0] d_term_phys_addr,
  input  wire        d_store_fail_n,
  input  wire        d_stcx_word,
  input  wire        d_zero_block,
  input  wire        dcache_disabled,
  input  wire        d_rd_little_n_big,
  input  wire        wr_little_n_big,
  input  wire        i_term_ack_n,
  input  wire        i_term_err_n,
  input  wire        i_tlb_miss_n,
  input  wire        i_byte_ord_n,
  input  wire        i_tag_par_n,
  input  wire        i_data_par_n,
  input  wire        i_ext_err_n,
  input  wire [31:0] i_term_phys_addr,
  input  wire        i_rd_little_n_big,
  input  wire        var_len_encoding,
  input  wire        syn_clear,
  output reg         d_done,
  output reg         d_ok,
  output reg         d_err,
  output reg  [2:0]  d_err_kind,
  output reg  [2:0]  d_err_prio,
  output reg         d_err_invalid,
  output reg         d_guarded,
  output reg         d_uncached,
  output reg  [31:0] d_addr,
  output reg         d_rd_little,
  output reg         stcx_failed,
  output reg         stcx_cr_eq,
  output reg         resv_clear,
  output reg         i_done,
  output reg         i_ok,
  output reg         i_err,
  output reg  [2:0]  i_err_kind,
  output reg  [2:0]  i_err_prio,
  output reg         i_err_invalid,
  output reg  [31:0] i_addr,
  output reg         i_rd_little,
  output reg         i_var_len,
  output wire        wr_little,
  output reg         mc_event,
  output reg  [3:0]  mc_syndrome_reg
);
  wire [2:0] dk;
  wire [2:0] dp;
  wire       dinv;
  wire       dok;
  wire       dany;
  wire [2:0] ik;
  wire [2:0] ip;
  wire       iinv;
  wire       iok;
  wire       iany;
  wire       d_erracc;
  wire       i_erracc;
  wire       zb_self;
  wire       xfail;
  reg  [3:0] next_syn;

  teq_decode u_d (
    .term_ack_n  (d_term_ack_n),
    .term_err_n  (d_term_err_n),
    .tlb_miss_n  (d_tlb_miss_n),
    .align_err_n (d_align_err_n),
    .byte_ord_n  (d_byte_ord_n),
    .tag_par_n   (d_tag_par_n),
    .data_par_n  (d_data_par_n),
    .ext_err_n   (d_ext_err_n),
    .kind        (dk),
    .prio        (dp),
    .invalid     (dinv),
    .ok_done     (dok),
    .any_done    (dany)
  );

  // instruction side has no alignment qualifier
  teq_decode u_i (
    .term_ack_n  (i_term_ack_n),
    .term_err_n  (i_term_err_n),
    .tlb_miss_n  (i_tlb_miss_n),
    .align_err_n (1'b1),
    .byte_ord_n  (i_byte_ord_n),
    .tag_par_n   (i_tag_par_n),
    .data_par_n  (i_data_par_n),
    .ext_err_n   (i_ext_err_n),
    .kind        (ik),
    .prio        (ip),
    .invalid     (iinv),
    .ok_done     (iok),
    .any_done    (iany)
  );

  assign d_erracc = ~d_term_err_n;
  assign i_erracc = ~i_term_err_n;
  // disabled cache: core faults zero-block on its own completion
  assign zb_self  = dok & d_zero_block & dcache_disabled;
  assign xfail    = dok & ~d_store_fail_n & d_stcx_word;
  assign wr_little = wr_little_n_big;

  always @* begin
    next_syn = mc_syndrome_reg;
    if (syn_clear)
      next_syn = `TEQ_SYN_RST;
    // hardware set wins over software clear
    if (i_erracc && ik == `TEQ_KIND_TAGPAR)
      next_syn[`TEQ_SYN_ITAG] = 1'b1;
    if (i_erracc && ik == `TEQ_KIND_DATAPAR)
      next_syn[`TEQ_SYN_IDATA] = 1'b1;
    if (d_erracc && dk == `TEQ_KIND_TAGPAR)
      next_syn[`TEQ_SYN_DTAG] = 1'b1;
    if (d_erracc && dk == `TEQ_KIND_DATAPAR)
      next_syn[`TEQ_SYN_DDATA] = 1'b1;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      d_done          <= 1'b0;
      d_ok            <= 1'b0;
      d_err           <= 1'b0;
      d_err_kind      <= `TEQ_KIND_NONE;
      d_err_prio      <= `TEQ_PRI_NONE;
      d_err_invalid   <= 1'b0;
      d_guarded       <= 1'b0;
      d_uncached      <= 1'b0;
      d_addr          <= `TEQ_ADDR_RST;
      d_rd_little     <= 1'b0;
      stcx_failed     <= 1'b0;
      stcx_cr_eq      <= 1'b0;
      resv_clear      <= 1'b0;
      i_done          <= 1'b0;
      i_ok            <= 1'b0;
      i_err           <= 1'b0;
      i_err_kind      <= `TEQ_KIND_NONE;
      i_err_prio      <= `TEQ_PRI_NONE;
      i_err_invalid   <= 1'b0;
      i_addr          <= `TEQ_ADDR_RST;
      i_rd_little     <= 1'b0;
      i_var_len       <= 1'b0;
      mc_event        <= 1'b0;
      mc_syndrome_reg <= `TEQ_SYN_RST;
    end else if (clk_en) begin
      d_done      <= dany;
      d_ok        <= dok & ~zb_self;
      d_err       <= d_erracc | zb_self;
      i_done      <= iany;
      i_ok        <= iok;
      i_err       <= i_erracc;
      stcx_failed <= xfail;
      stcx_cr_eq  <= dok & d_stcx_word & d_store_fail_n;
      resv_clear  <= xfail;
      mc_event    <= (d_erracc & (dk == `TEQ_KIND_TAGPAR
                      | dk == `TEQ_KIND_DATAPAR))
                   | (i_erracc & (ik == `TEQ_KIND_TAGPAR
                      | ik == `TEQ_KIND_DATAPAR));
      mc_syndrome_reg <= next_syn;
      if (dany) begin
        d_guarded   <= term_guarded;
        d_uncached  <= term_uncached;
        d_addr      <= d_term_phys_addr;
        d_rd_little <= d_rd_little_n_big;
        if (zb_self) begin
          d_err_kind    <= `TEQ_KIND_ALIGN;
          d_err_prio    <= `TEQ_PRI_ALIGN;
          d_err_invalid <= 1'b0;
        end else begin
          d_err_kind    <= dk;
          d_err_prio    <= dp;
          d_err_invalid <= dinv;
        end
      end
      if (iany) begin
        i_addr        <= i_term_phys_addr;
        i_rd_little   <= i_rd_little_n_big;
        i_var_len     <= var_len_encoding;
        i_err_kind    <= ik;
        i_err_prio    <= ip;
        i_err_invalid <= iinv;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/teq_far_model.sv
// far-side model: caches, mmu and bus unit ending accesses
`default_nettype none
module teq_far_model (
  input  wire logic [3:0] code,
  output logic            ack_n,
  output logic            err_n,
  output logic [5:0]      qual_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // qual_n bits: tlb, align, byte order, tag, data, external
  always_comb begin
    ack_n  = !(code == 4'h1 || code == 4'hA);
    err_n  = !((code >= 4'h2 && code <= 4'h8) || code == 4'hA);
    qual_n = 6'h3F;
    // one qualifier at most; code 9 drives the tlb qualifier with no termination
    if (code >= 4'h3 && code <= 4'h8) begin
      qual_n[code - 4'h3] = 1'b0;
    end
    if (code == 4'h9) begin
      qual_n = 6'h3E;
    end
  end
endmodule
`default_nettype wire

// File: tb/teq_qualifier_monitor.sv
// assertions on the termination qualifier ports
`default_nettype none
module teq_qualifier_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        d_term_ack_n,
  input wire logic        d_term_err_n,
  input wire logic        d_tlb_miss_n,
  input wire logic        d_tag_par_n,
  input wire logic        d_zero_block,
  input wire logic        term_guarded,
  input wire logic [31:0] d_term_phys_addr,
  input wire logic        d_store_fail_n,
  input wire logic        d_stcx_word,
  input wire logic        d_ok,
  input wire logic        d_err,
  input wire logic [2:0]  d_err_prio,
  input wire logic [31:0] d_addr,
  input wire logic        d_guarded,
  input wire logic        stcx_failed,
  input wire logic        resv_clear,
  input wire logic        mc_event,
  input wire logic [3:0]  mc_syndrome_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic take = clk_en && !(d_term_ack_n && d_term_err_n);
  a_err_wins: assert property (
    clk_en && !d_term_err_n |=> d_err && !d_ok)
    else $error("error ack not an error");
  a_ok_clean: assert property (
    clk_en && !d_term_ack_n && d_term_err_n && !d_zero_block |=> d_ok)
    else $error("plain ack not a success");
  a_tlb_top: assert property (
    clk_en && !d_term_err_n && !d_tlb_miss_n |=> d_err_prio == 3'h0)
    else $error("tlb miss level wrong");
  a_parity_mc: assert property (
    clk_en && !d_term_err_n && d_tlb_miss_n && !d_tag_par_n
    |=> mc_event && mc_syndrome_reg[2])
    else $error("tag parity gave no machine check");
  a_addr_take: assert property (
    take |=> d_addr == $past(d_term_phys_addr))
    else $error("address not captured");
  a_guard_take: assert property (
    take |=> d_guarded == $past(term_guarded))
    else $error("guarded not captured");
  a_stcx_fail: assert property (
    clk_en && !d_term_ack_n && d_term_err_n && !d_store_fail_n && d_stcx_word
    |=> stcx_failed && resv_clear && !d_err)
    else $error("store fail not seen");
  a_stcx_skip: assert property (
    clk_en && !(d_term_err_n && d_stcx_word) |=> !stcx_failed)
    else $error("store fail not ignored");
  c_parity: cover property (mc_event);
  c_stcx: cover property (stcx_failed);
  c_ok: cover property (d_ok);
endmodule
bind teq_qualifier teq_qualifier_monitor u_mon (.*);
`default_nettype wire

// File: tb/tb_teq_qualifier.sv
// bench for the termination qualifier
`default_nettype none
module tb_teq_qualifier;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, clk_en = 1, term_guarded = 0, term_uncached = 0;
  logic d_store_fail_n = 1, d_stcx_word = 0, d_zero_block = 0;
  logic dcache_disabled = 0, syn_clear = 0, wr_little_n_big = 0;
  logic d_rd_little_n_big = 0, i_rd_little_n_big = 0, var_len_encoding = 0;
  logic [3:0] code = 0;
  logic [31:0] d_term_phys_addr = 0, i_term_phys_addr = 0;
  wire d_term_ack_n, d_term_err_n, d_tlb_miss_n, d_align_err_n, d_byte_ord_n;
  wire d_tag_par_n, d_data_par_n, d_ext_err_n;
  wire i_term_ack_n = d_term_ack_n, i_term_err_n = d_term_err_n;
  wire i_tlb_miss_n = d_tlb_miss_n, i_byte_ord_n = d_byte_ord_n;
  wire i_tag_par_n = d_tag_par_n, i_data_par_n = d_data_par_n;
  wire i_ext_err_n = d_ext_err_n;
  logic d_done, d_ok, d_err, d_err_invalid, d_guarded, d_uncached, d_rd_little;
  logic stcx_failed, stcx_cr_eq, resv_clear, i_done, i_ok, i_err, mc_event;
  logic i_err_invalid, i_rd_little, i_var_len, wr_little;
  logic [2:0] d_err_kind, d_err_prio, i_err_kind, i_err_prio;
  logic [31:0] d_addr, i_addr;
  logic [3:0] mc_syndrome_reg;
  int bad_count = 0, compares = 0;
  teq_qualifier dut (.*);
  teq_far_model fm (.code(code), .ack_n(d_term_ack_n), .err_n(d_term_err_n),
    .qual_n({d_ext_err_n, d_data_par_n, d_tag_par_n, d_byte_ord_n,
             d_align_err_n, d_tlb_miss_n}));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic term(input logic [3:0] c);
    @(posedge mclk) code <= c;
    @(posedge mclk) code <= 4'h0;
    #1;
  endtask
  task automatic t_decode;
    logic [5:0] e [2:8];
    e = '{6'h11, 6'h08, 6'h1A, 6'h22, 6'h2B, 6'h34, 6'h3D};
    for (int c = 2; c <= 8; c++) begin
      term(c[3:0]);
      chk({d_err, d_done, d_ok}, 3'b110);
      chk({d_err_kind, d_err_prio}, e[c]);
      chk({i_err_kind, i_err_prio}, c == 4 ? 6'h11 : e[c]);
      chk(mc_event, c == 6 || c == 7);
    end
    chk(mc_syndrome_reg, 4'hF);
    @(posedge mclk) syn_clear <= 1;
    @(posedge mclk) syn_clear <= 0;
    #1 chk(mc_syndrome_reg, 4'h0);
    $display("decode test done");
  endtask
  task automatic t_ok;
    @(posedge mclk) begin
      code <= 1;
      d_term_phys_addr <= 32'hA5C30F18;
      i_term_phys_addr <= 32'h5A3CF0E7;
      term_guarded <= 1;
      term_uncached <= 1;
    end
    // inputs change on the take edge itself, after the flops sample them
    @(posedge mclk) begin
      code <= 0;
      d_term_phys_addr <= 0;
      term_guarded <= 0;
    end
    #1 chk({d_ok, d_done, d_err, i_ok}, 4'hD);
    chk(d_addr, 32'hA5C30F18);
    chk(i_addr, 32'h5A3CF0E7);
    chk({d_guarded, d_uncached}, 2'b11);
    chk(d_err_prio, 3'h6);
    term(9);
    chk({d_done, d_err, mc_event}, 3'b000);
    term(10);
    chk({d_err, d_ok, d_err_kind}, 5'b10010);
    $display("termination test done");
  endtask
  task automatic t_stcx;
    @(posedge mclk) {d_stcx_word, d_store_fail_n} <= 2'b10;
    term(1);
    chk({stcx_failed, resv_clear, stcx_cr_eq, d_err}, 4'hC);
    term(10);
    chk(stcx_failed, 0);
    @(posedge mclk) d_stcx_word <= 0;
    term(1);
    chk(stcx_failed, 0);
    @(posedge mclk) {d_stcx_word, d_store_fail_n} <= 2'b11;
    term(1);
    chk({stcx_failed, stcx_cr_eq}, 2'b01);
    $display("store conditional test done");
  endtask
  task automatic t_mode;
    @(posedge mclk) begin
      {d_rd_little_n_big, i_rd_little_n_big} <= 2'b11;
      {var_len_encoding, wr_little_n_big} <= 2'b11;
      {d_zero_block, dcache_disabled} <= 2'b11;
    end
    term(1);
    chk({d_rd_little, i_rd_little, i_var_len, wr_little}, 4'hF);
    chk({d_err, d_ok, d_err_kind}, 5'b10011);
    @(posedge mclk) begin
      {d_rd_little_n_big, i_rd_little_n_big} <= 2'b00;
      {var_len_encoding, wr_little_n_big, dcache_disabled} <= 3'b000;
    end
    term(1);
    chk({d_rd_little, i_rd_little, i_var_len, wr_little}, 4'h0);
    chk(d_ok, 1);
    $display("mode test done");
  endtask
  // clock enable low must freeze every flop, terminations included
  task automatic t_freeze;
    @(posedge mclk) clk_en <= 0;
    term(3);
    chk({d_done, d_err, i_done, i_err}, 4'h0);
    chk({d_err_kind, i_err_kind}, 6'h00);
    @(posedge mclk) clk_en <= 1;
    term(2);
    chk({i_done, i_err, i_ok, i_err_kind}, 6'b110010);
    chk({d_err_invalid, i_err_invalid}, 2'b00);
    $display("freeze test done");
  endtask
  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    t_decode();
    t_ok();
    t_stcx();
    t_mode();
    t_freeze();
    close_out();
  end
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
